// *** src/dram_access_refresh_sequencer.sv ***
// DRAM access, hidden refresh and forced refresh sequencer core
module dram_access_refresh_sequencer
(
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic cpuClk,
    input  wire logic addrStrobeN,
    input  wire logic chipSelectN,
    input  wire logic readWrite,
    input  wire logic refreshRequestInN,
    input  wire logic waitN,
    input  wire logic anyDataStrobeN,
    input  wire logic hiddenRefreshDisableN,
    output logic      rowStrobeRequestN,
    output logic      cycleDoneN,
    output logic      accessDuringRefreshN,
    output logic      transferAckN,
    output logic      transferAckOe,
    output logic      refreshCycleN,
    output logic      delayStageBN,
    output logic      delayStageCN,
    output logic      delayStageDN
);

    pin_sync_if pinBus ();

    // Settled pin levels, active high where the pin is active low
    logic clkHigh;
    logic addrStrobe;
    logic chipSelect;
    logic isRead;
    logic refreshReq;
    logic waitReq;
    logic dataStrobe;
    logic hiddenEnable;
    logic clkPrev_reg;
    logic clkPrev_next;
    logic cpuRise;

    // Combinational group, modelled one system clock behind its inputs
    logic rasReg;
    logic rasNext;
    logic cycReg;
    logic cycNext;
    logic incyReg;
    logic incyNext;
    logic ackReg;
    logic ackNext;
    logic ackOeReg;
    logic ackOeNext;

    // Registered group, stepped on the processor clock rise
    logic mode_reg;
    logic mode_next;
    logic stageB_reg;
    logic stageB_next;
    logic stageC_reg;
    logic stageC_next;
    logic stageD_reg;
    logic stageD_next;
    logic refreshStart;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    assign pinBus.rawPins = {hiddenRefreshDisableN, anyDataStrobeN, waitN,
                             refreshRequestInN, readWrite, chipSelectN,
                             addrStrobeN, cpuClk};

    pin_synchroniser u_sync
    (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .pins    (pinBus.syncer)
    );

    // Active-low pins turned to active-high levels
    assign clkHigh      = pinBus.syncPins[dram_seq_pkg::PIN_CPU_CLK];
    assign addrStrobe   = ~pinBus.syncPins[dram_seq_pkg::PIN_ADDR_STROBE];
    assign chipSelect   = ~pinBus.syncPins[dram_seq_pkg::PIN_CHIP_SELECT];
    assign isRead       = pinBus.syncPins[dram_seq_pkg::PIN_READ_WRITE];
    assign refreshReq   = ~pinBus.syncPins[dram_seq_pkg::PIN_REFRESH_REQ];
    assign waitReq      = ~pinBus.syncPins[dram_seq_pkg::PIN_WAIT];
    assign dataStrobe   = ~pinBus.syncPins[dram_seq_pkg::PIN_DATA_STROBE];
    assign hiddenEnable = pinBus.syncPins[dram_seq_pkg::PIN_HIDDEN_DIS];

    ////////////////////////////////////////////////////////////////////////
    // Processor clock rising edge detector
    always_comb
    begin
        clkPrev_next = clkHigh;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            clkPrev_reg <= dram_seq_pkg::COMB_RESET;
        else
            clkPrev_reg <= clkPrev_next;
    end

    assign cpuRise = clkHigh & ~clkPrev_reg;

    ////////////////////////////////////////////////////////////////////////
    // Row strobe, cycle-done, collision flag and acknowledge equations
    always_comb
    begin
        // Row strobe request
        rasNext = (chipSelect & ~incyReg & addrStrobe & ~mode_reg
                   & stageD_reg & ~cycReg & ~clkHigh)
                | (~chipSelect & ~incyReg & addrStrobe & ~mode_reg
                   & stageB_reg & ~cycReg & hiddenEnable)
                | (chipSelect & incyReg & addrStrobe & ~mode_reg
                   & stageD_reg & ~cycReg & ~clkHigh)
                | (chipSelect & rasReg & ~mode_reg & addrStrobe)
                | (rasReg & ~mode_reg & stageB_reg);
        // Cycle-done
        cycNext = (~mode_reg & stageB_reg & stageC_reg & ~stageD_reg)
                | (cycReg & addrStrobe)
                | (~mode_reg & cycReg & ~clkHigh)
                | (~chipSelect & addrStrobe & ~mode_reg & ~stageB_reg
                   & ~stageC_reg & ~stageD_reg);
        // Access during forced refresh
        incyNext = (mode_reg & addrStrobe)
                 | (incyReg & stageD_reg & addrStrobe);
        // Acknowledge, only driven while selected
        ackOeNext = chipSelect;
        ackNext   = chipSelect &
                    ((addrStrobe & ~waitReq & ~isRead & ~mode_reg & ~clkHigh)
                   | (addrStrobe & waitReq & ~isRead & ~mode_reg
                      & stageB_reg & ~clkHigh)
                   | (dataStrobe & ~waitReq & isRead & ~mode_reg & ~clkHigh)
                   | (dataStrobe & waitReq & isRead & ~mode_reg
                      & stageB_reg & ~clkHigh)
                   | (ackReg & stageB_reg & ~mode_reg)
                   | (ackReg & addrStrobe & rasReg & ~mode_reg
                      & ~cycReg)
                   | (ackReg & addrStrobe & ~isRead & ~mode_reg));
    end

    // Registers the combinational group every system clock
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rasReg   <= dram_seq_pkg::COMB_RESET;
            cycReg   <= dram_seq_pkg::COMB_RESET;
            incyReg  <= dram_seq_pkg::COMB_RESET;
            ackReg   <= dram_seq_pkg::COMB_RESET;
            ackOeReg <= dram_seq_pkg::COMB_RESET;
        end
        else
        begin
            rasReg   <= rasNext;
            cycReg   <= cycNext;
            incyReg  <= incyNext;
            ackReg   <= ackNext;
            ackOeReg <= ackOeNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Refresh mode and delay chain, stepped only on processor clock rise
    always_comb
    begin
        // Refresh request during a long cycle, selected or not; forces refresh only when selected
        refreshStart = refreshReq & addrStrobe & cycReg & ~stageB_reg
                     & ~stageC_reg & ~rasReg;
        mode_next   = mode_reg;
        stageB_next = stageB_reg;
        stageC_next = stageC_reg;
        stageD_next = stageD_reg;
        if (cpuRise)
        begin
            // Mode entry and hold
            mode_next = (refreshReq & ~addrStrobe & ~cycReg & ~rasReg)
                      | (chipSelect & refreshStart)
                      | (mode_reg & ~stageC_reg)
                      | (mode_reg & ~stageD_reg);
            // Stage B
            stageB_next = (mode_reg & ~stageD_reg)
                        | (~incyReg & addrStrobe & ~cycReg & ~mode_reg
                           & ~stageC_reg & stageD_reg)
                        | (chipSelect & incyReg & addrStrobe & ~cycReg
                           & ~mode_reg & ~stageC_reg & stageD_reg)
                        | (~mode_reg & stageB_reg & ~stageC_reg)
                        | (chipSelect & waitReq & addrStrobe & ~mode_reg
                           & stageB_reg & stageC_reg & ~stageD_reg)
                        | (chipSelect & addrStrobe & ~isRead & cycReg
                           & ~mode_reg & ~stageB_reg & ~stageC_reg
                           & ~stageD_reg);
            // Stages C and D
            stageC_next = stageB_reg & ~stageD_reg;
            stageD_next = stageC_reg
                        | (~addrStrobe & ~mode_reg)
                        | (~chipSelect & refreshStart & ~mode_reg);
        end
    end

    // Registers the mode and delay chain
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_reg   <= dram_seq_pkg::MODE_RESET;
            stageB_reg <= dram_seq_pkg::STAGE_B_RESET;
            stageC_reg <= dram_seq_pkg::STAGE_C_RESET;
            stageD_reg <= dram_seq_pkg::STAGE_D_RESET;
        end
        else
        begin
            mode_reg   <= mode_next;
            stageB_reg <= stageB_next;
            stageC_reg <= stageC_next;
            stageD_reg <= stageD_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs from flops, active low except transferAckOe
    assign rowStrobeRequestN    = ~rasReg;
    assign cycleDoneN           = ~cycReg;
    assign accessDuringRefreshN = ~incyReg;
    assign transferAckN         = ~ackReg;
    assign transferAckOe        = ackOeReg;
    assign refreshCycleN        = ~mode_reg;
    assign delayStageBN         = ~stageB_reg;
    assign delayStageCN         = ~stageC_reg;
    assign delayStageDN         = ~stageD_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_ras_start;
        chipSelect & addrStrobe & ~mode_reg & stageD_reg & ~cycReg
            & ~clkHigh |=> rasReg;
    endproperty
    a_ras_start: assert property (p_ras_start)
        else $error("row strobe did not start on selected access");

    property p_ras_hidden;
        ~chipSelect & ~incyReg & addrStrobe & ~mode_reg & stageB_reg
            & ~cycReg & hiddenEnable |=> !rowStrobeRequestN;
    endproperty
    a_ras_hidden: assert property (p_ras_hidden)
        else $error("hidden refresh row strobe missing");

    property p_cyc_start;
        ~mode_reg & stageB_reg & stageC_reg & ~stageD_reg |=> !cycleDoneN;
    endproperty
    a_cyc_start: assert property (p_cyc_start)
        else $error("cycle-done did not start");

    property p_cyc_other;
        ~chipSelect & addrStrobe & ~mode_reg
            & ({stageB_reg, stageC_reg, stageD_reg} == 3'h0) |=> cycReg;
    endproperty
    a_cyc_other: assert property (p_cyc_other)
        else $error("cycle-done missing for other device");

    property p_incy_set;
        mode_reg && addrStrobe |=> !accessDuringRefreshN;
    endproperty
    a_incy_set: assert property (p_incy_set)
        else $error("collision flag not set");

    property p_ack_unselected;
        !chipSelect |=> !ackReg && !transferAckOe;
    endproperty
    a_ack_unselected: assert property (p_ack_unselected)
        else $error("acknowledge driven while unselected");

    property p_ack_zero_wait;
        chipSelect & addrStrobe & ~waitReq & ~isRead & ~mode_reg
            & ~clkHigh |=> ackReg ##0 transferAckOe;
    endproperty
    a_ack_zero_wait: assert property (p_ack_zero_wait)
        else $error("zero wait write acknowledge missing");

    property p_mode_enter;
        cpuRise & refreshReq & ~addrStrobe & ~cycReg & ~rasReg
            |=> !refreshCycleN;
    endproperty
    a_mode_enter: assert property (p_mode_enter)
        else $error("forced refresh mode not entered");

    property p_chain_hold;
        !cpuRise |=> $stable({mode_reg, stageB_reg, stageC_reg, stageD_reg});
    endproperty
    a_chain_hold: assert property (p_chain_hold)
        else $error("delay chain moved without processor clock rise");

    property p_stage_c;
        cpuRise |=> stageC_reg == ($past(stageB_reg) & ~$past(stageD_reg));
    endproperty
    a_stage_c: assert property (p_stage_c)
        else $error("stage C does not follow stage B");

endmodule : dram_access_refresh_sequencer

// *** src/dram_seq_pkg.sv ***
// Shared constants for the DRAM access and refresh sequencer
package dram_seq_pkg;

    // Unused pin count; the input synchroniser passes PIN_TOTAL (8) pins
    localparam int unsigned PIN_COUNT = 7;

    // Bit positions of each pin inside the synchroniser vector
    localparam int unsigned PIN_CPU_CLK      = 0;
    localparam int unsigned PIN_ADDR_STROBE  = 1;
    localparam int unsigned PIN_CHIP_SELECT  = 2;
    localparam int unsigned PIN_READ_WRITE   = 3;
    localparam int unsigned PIN_REFRESH_REQ  = 4;
    localparam int unsigned PIN_WAIT         = 5;
    localparam int unsigned PIN_DATA_STROBE  = 6;
    localparam int unsigned PIN_HIDDEN_DIS   = 7;
    localparam int unsigned PIN_TOTAL        = 8;

    // Synchroniser reset level for every pin (all pins idle high except the processor clock, low)
    localparam logic [PIN_TOTAL-1:0] PIN_RESET = 8'hfe;

    // Reset values of the internal, active-high state
    localparam logic MODE_RESET    = 1'b0;
    localparam logic STAGE_B_RESET = 1'b0;
    localparam logic STAGE_C_RESET = 1'b0;
    localparam logic STAGE_D_RESET = 1'b1;
    localparam logic COMB_RESET    = 1'b0;

endpackage : dram_seq_pkg

// *** src/pin_sync_if.sv ***
// Carrier between the sequencer core and its pin synchroniser
interface pin_sync_if;

    logic [dram_seq_pkg::PIN_TOTAL-1:0] rawPins;
    logic [dram_seq_pkg::PIN_TOTAL-1:0] syncPins;

    // Synchroniser side: takes raw pins, returns settled pins
    modport syncer
    (
        input  rawPins,
        output syncPins
    );

    // Core side: hands over raw pins, reads settled pins
    modport core
    (
        output rawPins,
        input  syncPins
    );

endinterface : pin_sync_if

// *** src/pin_synchroniser.sv ***
// Two-flop synchroniser bank for all asynchronous pins
module pin_synchroniser
(
    input  wire logic   clk_sys,
    input  wire logic   rstn,
    pin_sync_if.syncer  pins
);

    logic [dram_seq_pkg::PIN_TOTAL-1:0] firstStage_reg;
    logic [dram_seq_pkg::PIN_TOTAL-1:0] secondStage_reg;

    ////////////////////////////////////////////////////////////////////////
    // One pair of flops per pin; first flop feeds only the second
    genvar bitIdx;
    generate
        for (bitIdx = 0; bitIdx < dram_seq_pkg::PIN_TOTAL; bitIdx++)
        begin : g_sync
            always_ff @(posedge clk_sys or negedge rstn)
            begin
                if (!rstn)
                begin
                    firstStage_reg[bitIdx]  <= dram_seq_pkg::PIN_RESET[bitIdx];
                    secondStage_reg[bitIdx] <= dram_seq_pkg::PIN_RESET[bitIdx];
                end
                else
                begin
                    firstStage_reg[bitIdx]  <= pins.rawPins[bitIdx];
                    secondStage_reg[bitIdx] <= firstStage_reg[bitIdx];
                end
            end
        end
    endgenerate

    // Settled pins leave through the interface
    assign pins.syncPins = secondStage_reg;

endmodule : pin_synchroniser

// *** tb/dram_ctrl_model.sv ***
// Refresh requester standing in for the external DRAM controller
module dram_ctrl_model
(
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic refreshDue,
    input  wire logic refreshCycleN,
    output logic      refreshRequestInN
);
    timeunit 1ns;
    timeprecision 1ps;

    // Request raised on demand, dropped once refresh mode is granted
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            refreshRequestInN <= 1'b1;
        else if (refreshDue)
            refreshRequestInN <= 1'b0;
        else if (!refreshCycleN)
            refreshRequestInN <= 1'b1;
    end

endmodule : dram_ctrl_model

// *** tb/dram_access_refresh_sequencer_bench.sv ***
// Self-checking bench for the DRAM access and refresh sequencer
module dram_access_refresh_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        cpuClk = 1'b0;
    logic        addrStrobeN = 1'b1;
    logic        chipSelectN = 1'b1;
    logic        readWrite = 1'b1;
    logic        waitN = 1'b1;
    logic        anyDataStrobeN = 1'b1;
    logic        hiddenRefreshDisableN = 1'b1;
    logic        refreshDue = 1'b0;
    logic        refreshRequestInN;
    logic        rowStrobeRequestN, cycleDoneN, accessDuringRefreshN;
    logic        transferAckN, transferAckOe, refreshCycleN;
    logic        delayStageBN, delayStageCN, delayStageDN;
    int          err_total = 0;
    int          check_count = 0;
    // Reference state and settled combinational terms, active high
    logic        mode = 1'b0, stB = 1'b0, stC = 1'b0, stD = 1'b1;
    logic        rowReq = 1'b0, done = 1'b0, collide = 1'b0, ack = 1'b0;
    logic        aStb, sel, rd, wt, uds, hd, rf;
    logic [31:0] seed = 32'ha8d94693;

    // Free-running system clock
    initial
    begin
        forever #2 clk_sys = ~clk_sys;
    end

    dram_access_refresh_sequencer dut
    (
        .clk_sys(clk_sys), .rstn(rstn), .cpuClk(cpuClk),
        .addrStrobeN(addrStrobeN), .chipSelectN(chipSelectN),
        .readWrite(readWrite), .refreshRequestInN(refreshRequestInN),
        .waitN(waitN), .anyDataStrobeN(anyDataStrobeN),
        .hiddenRefreshDisableN(hiddenRefreshDisableN),
        .rowStrobeRequestN(rowStrobeRequestN), .cycleDoneN(cycleDoneN),
        .accessDuringRefreshN(accessDuringRefreshN),
        .transferAckN(transferAckN), .transferAckOe(transferAckOe),
        .refreshCycleN(refreshCycleN), .delayStageBN(delayStageBN),
        .delayStageCN(delayStageCN), .delayStageDN(delayStageDN)
    );

    dram_ctrl_model ctrl
    (
        .clk_sys(clk_sys), .rstn(rstn), .refreshDue(refreshDue),
        .refreshCycleN(refreshCycleN),
        .refreshRequestInN(refreshRequestInN)
    );

    ////////////////////////////////////////////////////////////////////////
    // Random source
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Compare one output and count it
    task automatic check(input string what, input logic seen,
                         input logic expected);
        check_count++;
        if (seen !== expected)
        begin
            $display("[FAIL] %s expected %b seen %b", what, expected, seen);
            err_total++;
        end
    endtask : check

    // One pass of the combinational feedback terms
    task automatic comb_step(input logic k);
        logic nr, nc, ni, na;
        nr = (sel & aStb & !mode & stD & !done & !k)
           | (!sel & !collide & aStb & !mode & stB & !done & hd)
           | (sel & rowReq & !mode & aStb) | (rowReq & !mode & stB);
        nc = (!mode & stB & stC & !stD) | (done & aStb) | (!mode & done & !k)
           | (!sel & aStb & !mode & !stB & !stC & !stD);
        ni = (mode & aStb) | (collide & stD & aStb);
        na = sel & ((aStb & !rd & !mode & !k & (!wt | stB))
           | (uds & rd & !mode & !k & (!wt | stB)) | (ack & stB & !mode)
           | (ack & aStb & rowReq & !mode & !done)
           | (ack & aStb & !rd & !mode));
        {rowReq, done, collide, ack} = {nr, nc, ni, na};
    endtask : comb_step

    // Processor clock rise: registered terms, then settle with clock high
    task automatic clock_rise();
        logic nm, nb, nc, nd;
        nm = (rf & !aStb & !done & !rowReq) | (mode & !stC) | (mode & !stD)
           | (sel & rf & aStb & done & !stB & !stC & !rowReq);
        nb = (mode & !stD) | (!collide & aStb & !done & !mode & !stC & stD)
           | (sel & collide & aStb & !done & !mode & !stC & stD)
           | (!mode & stB & !stC) | (sel & wt & aStb & !mode & stB & stC & !stD)
           | (sel & aStb & !rd & done & !mode & !stB & !stC & !stD);
        nc = stB & !stD;
        nd = stC | (!aStb & !mode)
           | (!sel & rf & aStb & done & !stB & !stC & !rowReq & !mode);
        comb_step(1'b1);
        {mode, stB, stC, stD} = {nm, nb, nc, nd};
        repeat (5) comb_step(1'b1);
    endtask : clock_rise

    // Compare the outputs with the reference, transferAckN only while selected
    task automatic compare_all();
        check("rowStrobeRequestN", rowStrobeRequestN, !rowReq);
        check("cycleDoneN", cycleDoneN, !done);
        check("accessDuringRefreshN", accessDuringRefreshN, !collide);
        check("transferAckOe", transferAckOe, sel);
        if (sel)
            check("transferAckN", transferAckN, !ack);
        check("refreshCycleN", refreshCycleN, !mode);
        check("delayStageBN", delayStageBN, !stB);
        check("delayStageCN", delayStageCN, !stC);
        check("delayStageDN", delayStageDN, !stD);
    endtask : compare_all

    // Bus pins {as, cs, rw, wait, ds, hidden} held for n processor clocks
    task automatic bus(input logic [5:0] p, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_sys);
            cpuClk <= 1'b0;
            {addrStrobeN, chipSelectN, readWrite} <= p[5:3];
            {waitN, anyDataStrobeN, hiddenRefreshDisableN} <= p[2:0];
            repeat (7) @(posedge clk_sys);
            @(negedge clk_sys);
            {aStb, sel, rd, wt, uds, hd} = {!p[5], !p[4], p[3], !p[2], !p[1], p[0]};
            rf = !refreshRequestInN;
            repeat (6) comb_step(1'b0);
            compare_all();
            @(posedge clk_sys);
            cpuClk <= 1'b1;
            repeat (7) @(posedge clk_sys);
            @(negedge clk_sys);
            clock_rise();
            compare_all();
        end
    endtask : bus

    // Raise a refresh demand at the far side
    task automatic ask_refresh();
        @(posedge clk_sys);
        refreshDue <= 1'b1;
        @(posedge clk_sys);
        refreshDue <= 1'b0;
    endtask : ask_refresh

    // Verdict and end of run
    task automatic finish_test();
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        err_total++;
        finish_test();
    end

    // Corner cases, then random bus traffic
    initial
    begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        check("delayStageDN", delayStageDN, 1'b0);
        check("refreshCycleN", refreshCycleN, 1'b1);
        @(posedge clk_sys);
        rstn <= 1'b1;
        bus(6'b111111, 3);
        bus(6'b001101, 5);
        bus(6'b111111, 2);
        bus(6'b001001, 6);
        bus(6'b111111, 2);
        bus(6'b000111, 5);
        bus(6'b111111, 2);
        bus(6'b000011, 6);
        bus(6'b111111, 2);
        bus(6'b001101, 3);
        bus(6'b000101, 5);
        bus(6'b111111, 2);
        ask_refresh();
        bus(6'b111111, 6);
        ask_refresh();
        bus(6'b111111, 1);
        bus(6'b001101, 8);
        bus(6'b111111, 2);
        bus(6'b011111, 3);
        ask_refresh();
        bus(6'b011111, 6);
        bus(6'b011110, 4);
        bus(6'b111111, 2);
        bus(6'b001101, 3);
        ask_refresh();
        bus(6'b001101, 8);
        bus(6'b111111, 3);
        for (int i = 0; i < 400; i++)
        begin
            seed = lfsr_next(seed);
            if (seed[10:7] == 4'h0)
                ask_refresh();
            bus(seed[5:0], 1);
        end
        bus(6'b111111, 4);
        finish_test();
    end

endmodule : dram_access_refresh_sequencer_bench
